// File: rtl/msr_pkg.sv
package msr_pkg;

	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [5:0] ADDR_BLOCK_SEL = 6'h0b;
	localparam logic [5:0] ADDR_RAM_ADDR = 6'h0c;
	localparam logic [5:0] ADDR_RAM_DATA = 6'h0d;
	localparam logic [5:0] ADDR_WAKE_DISP = 6'h0e;
	localparam logic [5:0] ADDR_FLAGS = 6'h0f;
	localparam logic [5:0] ADDR_COMMON_LO = 6'h10;
	localparam logic [5:0] ADDR_BANKED_LO = 6'h20;
	localparam logic [3:0] IOC_PORT5 = 4'h5;
	localparam logic [3:0] IOC_PORT6 = 4'h6;
	localparam logic [3:0] IOC_PORT7 = 4'h7;
	localparam logic [3:0] IOC_PORT8 = 4'h8;
	localparam logic [3:0] IOC_PORT9 = 4'h9;
	localparam logic [1:0] BANK_NONE = 2'h3;

	// ****************************************
	// Writable bit masks and reset values
	// ****************************************
	localparam logic [7:0] MASK_BLOCK_SEL = 8'h01;
	localparam logic [7:0] MASK_WAKE_DISP = 8'h76;
	localparam logic [7:0] MASK_FLAGS = 8'h3f;
	localparam logic [7:0] MASK_TIMER_PRESCALE_CONTROL = 8'hef;
	localparam logic [7:0] MASK_NIBBLE_HI = 8'hf0;
	localparam logic [7:0] MASK_NIBBLE_LO = 8'h0f;
	localparam logic [7:0] MASK_R2F_PINS = 8'h1f;
	localparam logic [7:0] RST_TIMER_PRESCALE_CONTROL = 8'haf;
	localparam logic [7:0] RST_PORT5_DIR = 8'hf0;
	localparam logic [7:0] RST_PORT6_DIR = 8'hff;
	localparam logic [7:0] RST_PORT7_DIR = 8'hff;
	localparam logic [7:0] RST_PORT8_DIR = 8'h0f;
	localparam logic [7:0] RST_PORT9_DIR = 8'hc0;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DISP_LO_BIT = 1;
	localparam int WAKE96_BIT = 4;
	localparam int WAKE97_BIT = 5;
	localparam int WDT_EN_BIT = 6;
	localparam int PAB_BIT = 3;
	localparam int TS_BIT = 5;
	localparam int GIE_BIT = 6;
	localparam int EDGE_BIT = 7;
	localparam int COMMON_WORDS = 112;

	typedef struct packed {
		logic timerOverflow;
		logic counter1Overflow;
		logic counter2Overflow;
		logic [3:0] port7Pins;
	} msr_event_s;

	typedef struct packed {
		logic disableIrqInstruction;
		logic enableIrqInstruction;
		logic returnFromIrqInstruction;
		logic irqEntry;
	} msr_irqctl_s;

endpackage

// File: rtl/msr_register_bank.sv
`timescale 1ns/1ps
// How it works
// - Block select bit picks one RAM half
// - Eight-bit RAM address, reset zero
// - Data window reads and writes addressed byte
// - Display field: 00 off, 01 blank, 11 on
// - Wake enables for pins 96 and 97
// - Watchdog enable bit, reset zero
// - Timer overflow sets flag bit 0
// - Pin flags only while pin is input
// - Counter overflows set flag bits 4, 5
// - Flags readable, software clears them
// - Pin 0 edge type, reset falling only
// - Banked registers exist in banks 0-2 only
// - Three-bit ratio, reset all ones
// - Assign bit: timer or watchdog, reset 1
// - Instruction clock is half core clock
// - Global enable follows disable, enable, return
// - Direction 0 drives, 1 floats; resets
// - Port 6 low bits read zero in R2F
// - Control register only via its own instructions
module msr_register_bank (
	input wire logic clk,
	input wire logic reset,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [5:0] regAddr,
	input wire logic [1:0] bankSelect,
	input wire logic iocWrite,
	input wire logic iocRead,
	input wire logic [3:0] iocAddr,
	input wire logic controlWriteInstruction,
	input wire logic controlReadInstruction,
	input wire logic [7:0] writeData,
	input wire msr_pkg::msr_event_s events,
	input wire msr_pkg::msr_irqctl_s irqCtl,
	input wire logic subClockTick,
	input wire logic watchdogClockTick,
	input wire logic r2fEnable,
	output logic [7:0] readData,
	output logic readValid,
	output logic ramBlockSelect,
	output logic [7:0] generalRamAddress,
	output logic displayEnable,
	output logic displayBlank,
	output logic pin96WakeEnable,
	output logic pin97WakeEnable,
	output logic watchdogEnable,
	output logic [7:0] pendingRequestFlags,
	output logic globalIrqEnable,
	output logic [7:0] timerPrescaleControl,
	output logic timerTick,
	output logic watchdogTick,
	output logic [7:0] port5Direction,
	output logic [7:0] port6Direction,
	output logic [7:0] port7Direction,
	output logic [7:0] port8Direction,
	output logic [7:0] port9Direction
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [6:0] commonIndex(input logic [5:0] addr, input logic [1:0] bank);
		logic [6:0] idx;
		idx = 7'h00;
		if (addr < msr_pkg::ADDR_BANKED_LO) begin
			idx = {3'h0, addr[3:0]};
		end else begin
			idx = 7'h10 + {bank, 5'h00} + {2'h0, addr[4:0]};
		end
		return idx;
	endfunction

	function automatic logic [7:0] lowMask(input logic [3:0] n);
		return 8'((9'h001 << n) - 9'h001);
	endfunction

	function automatic logic [7:0] maskedWrite(input logic [7:0] old, input logic [7:0] data,
		input logic [7:0] mask);
		return (old & ~mask) | (data & mask);
	endfunction

	logic blockSel_reg;
	logic [7:0] ramAddr_reg;
	logic [7:0] wakeDisp_reg;
	logic [7:0] flags_reg;
	logic [7:0] flags_next;
	logic [7:0] timer_prescale_control_reg;
	logic [7:0] dir5_reg;
	logic [7:0] dir6_reg;
	logic [7:0] dir7_reg;
	logic [7:0] dir8_reg;
	logic [7:0] dir9_reg;
	logic [7:0] readData_reg;
	logic [7:0] readData_next;
	logic readValid_reg;
	logic dispOn_reg;
	logic dispBlank_reg;
	logic [3:0] pinPrev_reg;
	logic instrPhase_reg;
	logic [7:0] presc_reg;
	logic timerTick_reg;
	logic wdtTick_reg;
	logic [7:0] generalRam [512];
	logic [7:0] commonRam [msr_pkg::COMMON_WORDS];

	logic isCommon;
	logic bankOk;
	logic [8:0] ramIndex;
	assign isCommon = regAddr >= msr_pkg::ADDR_COMMON_LO;
	// Bank 3 has no storage behind it for the banked range
	assign bankOk = (regAddr < msr_pkg::ADDR_BANKED_LO) || (bankSelect != msr_pkg::BANK_NONE);
	assign ramIndex = {blockSel_reg, ramAddr_reg};

	// ****************************************
	// General RAM window and address
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			blockSel_reg <= 1'b0;
			ramAddr_reg <= 8'h00;
		end else if (regWrite) begin
			if (regAddr == msr_pkg::ADDR_BLOCK_SEL) begin
				blockSel_reg <= writeData[0];
			end
			if (regAddr == msr_pkg::ADDR_RAM_ADDR) begin
				ramAddr_reg <= writeData;
			end
		end
	end

	// RAM holds no reset so it maps onto a plain memory macro
	always_ff @(posedge clk) begin
		if (regWrite && regAddr == msr_pkg::ADDR_RAM_DATA) begin
			generalRam[ramIndex] <= writeData;
		end
		if (regWrite && isCommon && bankOk) begin
			commonRam[commonIndex(regAddr, bankSelect)] <= writeData;
		end
	end

	// ****************************************
	// Wake-up and display control
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wakeDisp_reg <= 8'h00;
		end else if (regWrite && regAddr == msr_pkg::ADDR_WAKE_DISP) begin
			wakeDisp_reg <= maskedWrite(wakeDisp_reg, writeData, msr_pkg::MASK_WAKE_DISP);
		end
	end

	// Code 10 is undefined; treated as off so the panel never glitches on
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dispOn_reg <= 1'b0;
			dispBlank_reg <= 1'b0;
		end else begin
			dispOn_reg <= wakeDisp_reg[msr_pkg::DISP_LO_BIT +: 2] == 2'b11;
			dispBlank_reg <= wakeDisp_reg[msr_pkg::DISP_LO_BIT +: 2] == 2'b01;
		end
	end

	// ****************************************
	// Pending request flags
	// ****************************************
	logic [3:0] pinIsInput;
	logic [3:0] pinFall;
	logic [3:0] pinRise;
	logic [7:0] eventSet;
	assign pinIsInput = dir7_reg[3:0];
	assign pinFall = pinPrev_reg & ~events.port7Pins;
	assign pinRise = ~pinPrev_reg & events.port7Pins;

	always_comb begin
		eventSet = 8'h00;
		eventSet[0] = events.timerOverflow;
		eventSet[1] = pinIsInput[0] && (pinFall[0] ||
			(!timer_prescale_control_reg[msr_pkg::EDGE_BIT] && pinRise[0]));
		eventSet[2] = pinIsInput[1] && pinFall[1];
		eventSet[3] = |(pinIsInput[3:2] & pinFall[3:2]);
		eventSet[4] = events.counter1Overflow;
		eventSet[5] = events.counter2Overflow;
	end

	// A new event beats a software clear in the same cycle
	always_comb begin
		flags_next = flags_reg;
		if (regWrite && regAddr == msr_pkg::ADDR_FLAGS) begin
			flags_next = writeData & msr_pkg::MASK_FLAGS;
		end
		flags_next = flags_next | eventSet;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flags_reg <= 8'h00;
			// Pins idle high, so the first sample after reset shows no false edge
			pinPrev_reg <= 4'hf;
		end else begin
			flags_reg <= flags_next;
			pinPrev_reg <= events.port7Pins;
		end
	end

	// ****************************************
	// Control register and global enable
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			timer_prescale_control_reg <= msr_pkg::RST_TIMER_PRESCALE_CONTROL;
		end else begin
			if (controlWriteInstruction) begin
				timer_prescale_control_reg <= maskedWrite(timer_prescale_control_reg, writeData, msr_pkg::MASK_TIMER_PRESCALE_CONTROL);
			end
			if (irqCtl.disableIrqInstruction || irqCtl.irqEntry) begin
				timer_prescale_control_reg[msr_pkg::GIE_BIT] <= 1'b0;
			end else if (irqCtl.enableIrqInstruction || irqCtl.returnFromIrqInstruction) begin
				timer_prescale_control_reg[msr_pkg::GIE_BIT] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Prescaler and tick generation
	// ****************************************
	logic timerSource;
	logic prescSource;
	logic [3:0] prescShift;
	logic prescHit;
	// Instruction clock runs at half the core clock
	assign timerSource = timer_prescale_control_reg[msr_pkg::TS_BIT] ? subClockTick : instrPhase_reg;
	assign prescSource = timer_prescale_control_reg[msr_pkg::PAB_BIT] ? watchdogClockTick : timerSource;
	// Timer ratios start at 1:2, watchdog ratios at 1:1
	assign prescShift = {1'b0, timer_prescale_control_reg[2:0]} + {3'h0, !timer_prescale_control_reg[msr_pkg::PAB_BIT]};
	assign prescHit = prescSource && ((presc_reg & lowMask(prescShift)) == lowMask(prescShift));

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			instrPhase_reg <= 1'b0;
			presc_reg <= 8'h00;
			timerTick_reg <= 1'b0;
			wdtTick_reg <= 1'b0;
		end else begin
			instrPhase_reg <= !instrPhase_reg;
			if (prescSource) begin
				presc_reg <= presc_reg + 8'h01;
			end
			timerTick_reg <= timer_prescale_control_reg[msr_pkg::PAB_BIT] ? timerSource : prescHit;
			wdtTick_reg <= wakeDisp_reg[msr_pkg::WDT_EN_BIT] &&
				(timer_prescale_control_reg[msr_pkg::PAB_BIT] ? prescHit : watchdogClockTick);
		end
	end

	// ****************************************
	// Port direction registers
	// ****************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dir5_reg <= msr_pkg::RST_PORT5_DIR;
			dir6_reg <= msr_pkg::RST_PORT6_DIR;
			dir7_reg <= msr_pkg::RST_PORT7_DIR;
			dir8_reg <= msr_pkg::RST_PORT8_DIR;
			dir9_reg <= msr_pkg::RST_PORT9_DIR;
		end else if (iocWrite) begin
			unique case (iocAddr)
				msr_pkg::IOC_PORT5: dir5_reg <= writeData & msr_pkg::MASK_NIBBLE_HI;
				msr_pkg::IOC_PORT6: dir6_reg <= writeData;
				msr_pkg::IOC_PORT7: dir7_reg <= writeData;
				msr_pkg::IOC_PORT8: dir8_reg <= writeData & msr_pkg::MASK_NIBBLE_LO;
				msr_pkg::IOC_PORT9: dir9_reg <= writeData & msr_pkg::MASK_NIBBLE_HI;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		readData_next = 8'h00;
		if (controlReadInstruction) begin
			readData_next = timer_prescale_control_reg;
		end else if (iocRead) begin
			unique case (iocAddr)
				msr_pkg::IOC_PORT5: readData_next = dir5_reg;
				// Shared pins belong to the R2F counter while it runs
				msr_pkg::IOC_PORT6: readData_next = r2fEnable ?
					(dir6_reg & ~msr_pkg::MASK_R2F_PINS) : dir6_reg;
				msr_pkg::IOC_PORT7: readData_next = dir7_reg;
				msr_pkg::IOC_PORT8: readData_next = dir8_reg;
				msr_pkg::IOC_PORT9: readData_next = dir9_reg;
				default: readData_next = 8'h00;
			endcase
		end else if (regRead) begin
			if (isCommon) begin
				readData_next = bankOk ? commonRam[commonIndex(regAddr, bankSelect)] : 8'h00;
			end else begin
				unique case (regAddr)
					msr_pkg::ADDR_BLOCK_SEL: readData_next = {7'h00, blockSel_reg};
					msr_pkg::ADDR_RAM_ADDR: readData_next = ramAddr_reg;
					msr_pkg::ADDR_RAM_DATA: readData_next = generalRam[ramIndex];
					msr_pkg::ADDR_WAKE_DISP: readData_next = wakeDisp_reg;
					msr_pkg::ADDR_FLAGS: readData_next = flags_reg;
					default: readData_next = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readData_reg <= 8'h00;
			readValid_reg <= 1'b0;
		end else begin
			readData_reg <= readData_next;
			readValid_reg <= controlReadInstruction || iocRead || regRead;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign readData = readData_reg;
	assign readValid = readValid_reg;
	assign ramBlockSelect = blockSel_reg;
	assign generalRamAddress = ramAddr_reg;
	assign displayEnable = dispOn_reg;
	assign displayBlank = dispBlank_reg;
	assign pin96WakeEnable = wakeDisp_reg[msr_pkg::WAKE96_BIT];
	assign pin97WakeEnable = wakeDisp_reg[msr_pkg::WAKE97_BIT];
	assign watchdogEnable = wakeDisp_reg[msr_pkg::WDT_EN_BIT];
	assign pendingRequestFlags = flags_reg;
	assign globalIrqEnable = timer_prescale_control_reg[msr_pkg::GIE_BIT];
	assign timerPrescaleControl = timer_prescale_control_reg;
	assign timerTick = timerTick_reg;
	assign watchdogTick = wdtTick_reg;
	assign port5Direction = dir5_reg;
	assign port6Direction = dir6_reg;
	assign port7Direction = dir7_reg;
	assign port8Direction = dir8_reg;
	assign port9Direction = dir9_reg;

	// ****************************************
	// Assertions
	// ****************************************
	property p_block_write;
		@(posedge clk) disable iff (reset)
		regWrite && regAddr == msr_pkg::ADDR_BLOCK_SEL |=> ramBlockSelect == $past(writeData[0]);
	endproperty
	a_block_write: assert property (p_block_write) else $error("block select not stored");

	property p_addr_write;
		@(posedge clk) disable iff (reset)
		regWrite && regAddr == msr_pkg::ADDR_RAM_ADDR |=> generalRamAddress == $past(writeData);
	endproperty
	a_addr_write: assert property (p_addr_write) else $error("RAM address not stored");

	property p_ram_roundtrip;
		@(posedge clk) disable iff (reset)
		(regWrite && regAddr == msr_pkg::ADDR_RAM_DATA && !iocRead && !controlReadInstruction)
		##1 (regRead && !regWrite && regAddr == msr_pkg::ADDR_RAM_DATA && !iocRead &&
		!controlReadInstruction)
		|=> readValid && readData == $past(writeData, 2);
	endproperty
	a_ram_roundtrip: assert property (p_ram_roundtrip) else $error("RAM window mismatch");

	property p_display_on;
		@(posedge clk) disable iff (reset)
		wakeDisp_reg[2:1] == 2'b11 |=> displayEnable && !displayBlank;
	endproperty
	a_display_on: assert property (p_display_on) else $error("display not enabled");

	property p_timer_flag;
		@(posedge clk) disable iff (reset)
		events.timerOverflow |=> pendingRequestFlags[0];
	endproperty
	a_timer_flag: assert property (p_timer_flag) else $error("timer flag lost");

	property p_counter_flags;
		@(posedge clk) disable iff (reset)
		events.counter1Overflow && events.counter2Overflow |=> pendingRequestFlags[5:4] == 2'b11;
	endproperty
	a_counter_flags: assert property (p_counter_flags) else $error("counter flag lost");

	property p_output_pin_quiet;
		@(posedge clk) disable iff (reset)
		!port7Direction[1] && !pendingRequestFlags[2] && !(regWrite && regAddr ==
		msr_pkg::ADDR_FLAGS) |=> !pendingRequestFlags[2];
	endproperty
	a_output_pin_quiet: assert property (p_output_pin_quiet) else $error("output pin flagged");

	property p_flag_clear;
		@(posedge clk) disable iff (reset)
		regWrite && regAddr == msr_pkg::ADDR_FLAGS && writeData == 8'h00 && eventSet == 8'h00
		|=> pendingRequestFlags == 8'h00;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared");

	property p_rise_mode;
		@(posedge clk) disable iff (reset)
		port7Direction[0] && !timerPrescaleControl[7] && !pinPrev_reg[0] && events.port7Pins[0]
		|=> pendingRequestFlags[1];
	endproperty
	a_rise_mode: assert property (p_rise_mode) else $error("rising edge missed");

	property p_bank3;
		@(posedge clk) disable iff (reset)
		regRead && !iocRead && !controlReadInstruction && bankSelect == 2'h3 && regAddr >= 6'h20
		|=> readData == 8'h00;
	endproperty
	a_bank3: assert property (p_bank3) else $error("bank 3 readable");

	property p_gie_off;
		@(posedge clk) disable iff (reset)
		irqCtl.disableIrqInstruction |=> !globalIrqEnable;
	endproperty
	a_gie_off: assert property (p_gie_off) else $error("enable not cleared");

	property p_r2f_read;
		@(posedge clk) disable iff (reset)
		iocRead && !controlReadInstruction && iocAddr == 4'h6 && r2fEnable
		|=> readData[4:0] == 5'h00 && readData[7:5] == $past(port6Direction[7:5]);
	endproperty
	a_r2f_read: assert property (p_r2f_read) else $error("R2F pins not zero");

	property p_timer_prescale_control_private;
		@(posedge clk) disable iff (reset)
		!controlWriteInstruction && !$rose(irqCtl.irqEntry) && irqCtl == '0
		|=> $stable(timerPrescaleControl);
	endproperty
	a_timer_prescale_control_private: assert property (p_timer_prescale_control_private) else $error("control changed");

endmodule

// File: tb/msr_register_bank_tb.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("unexpected %s: expected %h seen %h", what, exp, got); \
	end \
end
module msr_register_bank_tb;
	logic clk = 0;
	logic reset = 1;
	logic regWrite = 0, regRead = 0, iocWrite = 0, iocRead = 0;
	logic controlWriteInstruction = 0, controlReadInstruction = 0;
	logic [5:0] regAddr = 6'h00;
	logic [1:0] bankSelect = 2'h0;
	logic [3:0] iocAddr = 4'h0;
	logic [7:0] writeData = 8'h00;
	msr_pkg::msr_event_s events = '{default: 1'b0, port7Pins: 4'hf};
	msr_pkg::msr_irqctl_s irqCtl = '0;
	logic subClockTick = 0, watchdogClockTick = 0, r2fEnable = 0;
	logic [7:0] readData, pendingRequestFlags, timerPrescaleControl, generalRamAddress;
	logic [7:0] port5Direction, port6Direction, port7Direction, port8Direction, port9Direction;
	logic readValid, ramBlockSelect, displayEnable, displayBlank, pin96WakeEnable;
	logic pin97WakeEnable, watchdogEnable, globalIrqEnable, timerTick, watchdogTick;
	int checked = 0;
	int failures = 0;
	int tickCnt = 0;
	logic [7:0] dirMask [5] = '{8'hf0, 8'hff, 8'hff, 8'h0f, 8'hf0};
	logic [3:0] irqSeq [8] = '{4'h4, 4'h8, 4'h2, 4'h1, 4'h4, 4'hc, 4'h2, 4'h3};

	msr_register_bank i_dut (.clk, .reset, .regWrite, .regRead, .regAddr, .bankSelect,
		.iocWrite, .iocRead, .iocAddr, .controlWriteInstruction, .controlReadInstruction,
		.writeData, .events, .irqCtl, .subClockTick, .watchdogClockTick, .r2fEnable,
		.readData, .readValid, .ramBlockSelect, .generalRamAddress, .displayEnable,
		.displayBlank, .pin96WakeEnable, .pin97WakeEnable, .watchdogEnable,
		.pendingRequestFlags, .globalIrqEnable, .timerPrescaleControl, .timerTick,
		.watchdogTick, .port5Direction, .port6Direction, .port7Direction, .port8Direction,
		.port9Direction);

	always #10 clk = ~clk;

	// Watchdog base every fourth core cycle, sub clock every eighth
	always @(posedge clk) begin
		#1;
		tickCnt++;
		watchdogClockTick = (tickCnt % 4 == 0);
		subClockTick = (tickCnt % 8 == 0);
	end

	// ****************************************
	// Access tasks
	// ****************************************
	// kind 0 ordinary, 1 direction, 2 control
	task automatic access(input int kind, input logic wr, input logic [5:0] addr,
		input logic [7:0] data, output logic [7:0] rdata);
		@(posedge clk);
		#1;
		regAddr = addr;
		iocAddr = addr[3:0];
		writeData = data;
		regWrite = wr && kind == 0;
		regRead = !wr && kind == 0;
		iocWrite = wr && kind == 1;
		iocRead = !wr && kind == 1;
		controlWriteInstruction = wr && kind == 2;
		controlReadInstruction = !wr && kind == 2;
		@(posedge clk);
		#1;
		{regWrite, regRead, iocWrite, iocRead} = 4'h0;
		{controlWriteInstruction, controlReadInstruction} = 2'h0;
		rdata = 8'h00;
		// Read answer stands for the one cycle after the strobe edge
		if (!wr) begin
			`CHECK("read valid", 1'b1, readValid)
			rdata = readData;
		end
	endtask

	task automatic wr(input int kind, input logic [5:0] addr, input logic [7:0] data);
		logic [7:0] d;
		access(kind, 1'b1, addr, data, d);
	endtask

	task automatic chk(input int kind, input logic [5:0] addr, input logic [7:0] exp,
		input string what);
		logic [7:0] d;
		access(kind, 1'b0, addr, 8'h00, d);
		`CHECK(what, exp, d)
	endtask

	task automatic evt(input logic [2:0] e);
		@(posedge clk);
		#1;
		{events.timerOverflow, events.counter1Overflow, events.counter2Overflow} = e;
		@(posedge clk);
		#1;
		{events.timerOverflow, events.counter1Overflow, events.counter2Overflow} = 3'h0;
	endtask

	task automatic pins(input logic [3:0] v);
		@(posedge clk);
		#1;
		events.port7Pins = v;
		repeat (2) @(posedge clk);
	endtask

	// Windows of 64 cycles hold whole periods, so counts do not depend on phase
	task automatic ticks(input logic [7:0] ctl, input int expT, input int expW);
		int t;
		int w;
		t = 0;
		w = 0;
		wr(2, 6'h00, ctl);
		repeat (16) @(posedge clk);
		repeat (64) begin
			@(posedge clk);
			#1;
			t += timerTick;
			w += watchdogTick;
		end
		if (expT >= 0) `CHECK("timer ticks", expT, t)
		if (expW >= 0) `CHECK("watchdog ticks", expW, w)
	endtask

	task automatic results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#(20 * 20000);
		failures++;
		$display("unexpected timeout reached");
		results;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (20) @(posedge clk);
		#1;
		reset = 0;
		`CHECK("control reset", 8'haf, timerPrescaleControl)
		`CHECK("direction reset", 40'hf0ffff0fc0, {port5Direction, port6Direction,
			port7Direction, port8Direction, port9Direction})
		`CHECK("watchdog reset", 1'b0, watchdogEnable)
		`CHECK("ram address reset", 8'h00, generalRamAddress)
		chk(2, 6'h00, 8'haf, "control read");
		$display("test reset done");

		wr(0, 6'h0b, 8'hff);
		chk(0, 6'h0b, 8'h01, "block select");
		`CHECK("block output", 1'b1, ramBlockSelect)
		for (int i = 0; i < 4; i++) begin
			wr(0, 6'h0b, 8'(i[1]));
			wr(0, 6'h0c, {8{i[0]}});
			wr(0, 6'h0d, 8'h3c ^ 8'(i));
		end
		for (int i = 0; i < 4; i++) begin
			wr(0, 6'h0b, 8'(i[1]));
			wr(0, 6'h0c, {8{i[0]}});
			chk(0, 6'h0c, {8{i[0]}}, "ram address");
			chk(0, 6'h0d, 8'h3c ^ 8'(i), "ram data");
		end
		// Window write then read with no idle cycle between
		@(posedge clk);
		#1;
		{regAddr, writeData, regWrite} = {6'h0d, 8'h96, 1'b1};
		@(posedge clk);
		#1;
		{regWrite, regRead} = 2'b01;
		@(posedge clk);
		#1;
		regRead = 0;
		`CHECK("ram back to back", 9'h196, {readValid, readData})
		chk(0, 6'h03, 8'h00, "unmapped read");
		$display("test ram done");

		wr(0, 6'h0e, 8'hff);
		chk(0, 6'h0e, 8'h76, "wake display");
		`CHECK("wake outputs", 3'h7, {pin96WakeEnable, pin97WakeEnable, watchdogEnable})
		for (int c = 0; c < 4; c++) begin
			wr(0, 6'h0e, 8'(c << 1));
			repeat (2) @(posedge clk);
			#1;
			`CHECK("display", {c == 3, c == 1}, {displayEnable, displayBlank})
		end
		`CHECK("wake off", 3'h0, {pin96WakeEnable, pin97WakeEnable, watchdogEnable})
		$display("test wake done");

		wr(0, 6'h0f, 8'hff);
		chk(0, 6'h0f, 8'h3f, "flag mask");
		wr(0, 6'h0f, 8'h00);
		evt(3'h4);
		evt(3'h2);
		evt(3'h1);
		chk(0, 6'h0f, 8'h31, "overflow flags");
		`CHECK("flag output", 8'h31, pendingRequestFlags)
		wr(0, 6'h0f, 8'h00);
		chk(0, 6'h0f, 8'h00, "flags cleared");
		pins(4'he);
		chk(0, 6'h0f, 8'h02, "pin0 falling");
		wr(0, 6'h0f, 8'h00);
		pins(4'hf);
		chk(0, 6'h0f, 8'h00, "pin0 rising ignored");
		wr(2, 6'h00, 8'h2f);
		pins(4'he);
		wr(0, 6'h0f, 8'h00);
		pins(4'hf);
		chk(0, 6'h0f, 8'h02, "pin0 rising");
		pins(4'h5);
		chk(0, 6'h0f, 8'h0e, "pin1 pin3 falling");
		wr(1, 6'h07, 8'h00);
		pins(4'hf);
		wr(0, 6'h0f, 8'h00);
		pins(4'h0);
		chk(0, 6'h0f, 8'h00, "output pins ignored");
		$display("test flags done");

		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			irqCtl = irqSeq[i];
			@(posedge clk);
			#1;
			irqCtl = '0;
			`CHECK("global enable", ~i[0], globalIrqEnable)
		end
		wr(2, 6'h00, 8'hff);
		chk(2, 6'h00, 8'hef, "control mask");
		$display("test control done");

		for (int p = 5; p <= 9; p++) begin
			wr(1, 6'(p), 8'hff);
			chk(1, 6'(p), dirMask[p - 5], "direction set");
			wr(1, 6'(p), 8'h00);
			chk(1, 6'(p), 8'h00, "direction clear");
		end
		`CHECK("port8 output", 8'h00, port8Direction)
		chk(1, 6'h03, 8'h00, "unmapped direction");
		r2fEnable = 1;
		wr(1, 6'h06, 8'hff);
		chk(1, 6'h06, 8'he0, "r2f readback");
		r2fEnable = 0;
		$display("test direction done");

		wr(0, 6'h20, 8'h5a);
		wr(0, 6'h21, 8'h11);
		bankSelect = 2'h1;
		wr(0, 6'h20, 8'ha5);
		chk(0, 6'h20, 8'ha5, "bank 1");
		bankSelect = 2'h3;
		wr(0, 6'h21, 8'h77);
		chk(0, 6'h21, 8'h00, "bank 3 read");
		bankSelect = 2'h0;
		chk(0, 6'h20, 8'h5a, "bank 0 kept");
		chk(0, 6'h21, 8'h11, "bank 3 write dropped");
		$display("test banks done");

		wr(0, 6'h0e, 8'h40);
		ticks(8'h80, 16, -1);
		ticks(8'h82, 4, -1);
		ticks(8'h88, -1, 16);
		ticks(8'h89, -1, 8);
		ticks(8'ha0, 4, -1);
		wr(0, 6'h0e, 8'h00);
		ticks(8'h88, -1, 0);
		$display("test prescaler done");
		results;
	end
endmodule
